// File: src/fbm_pkg.sv
// Shared constants, pin carriers and state types of the flash bus front end
package fbm_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BLK_W  = 4;
  localparam int CNT_W  = 16;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS           = 8;
  localparam int RESET_LOW_PULSE_TIME_NS = 100;
  localparam int RESET_TO_READY_ERASE_US = 20;
  localparam int RESET_TO_READY_PROG_US  = 10;
  // Least time rounds up
  localparam int RESET_LOW_PULSE_CYC =
    (RESET_LOW_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest times round down
  localparam int RESET_TO_READY_ERASE_CYC = RESET_TO_READY_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int RESET_TO_READY_PROG_CYC  = RESET_TO_READY_PROG_US * 1000 / CLK_PERIOD_NS;

  // ****************************************
  // Commands
  // ****************************************
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT  = 8'h10;
  localparam logic [7:0] CMD_ERASE        = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;

  // ****************************************
  // Status register
  // ****************************************
  localparam int SR_READY     = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR  = 4;
  localparam int SR_PROGRAM_ENABLE_SUPPLY_ERR  = 3;
  localparam logic [7:0]        SR_RESET_VAL = 8'h80;
  localparam logic [7:0]        SR_CLEAR_MSK = 8'hC7;
  localparam logic [DATA_W-1:0] ERASED_WORD  = 16'hFFFF;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    FBM_ST_RESET = 5'h01,
    FBM_ST_WAKE  = 5'h02,
    FBM_ST_IDLE  = 5'h04,
    FBM_ST_PROG  = 5'h08,
    FBM_ST_ERASE = 5'h10
  } fbm_state_t;

  typedef enum logic [1:0] {
    FBM_SU_NONE  = 2'h0,
    FBM_SU_PROG  = 2'h1,
    FBM_SU_ERASE = 2'h2
  } fbm_setup_t;

  typedef struct packed {
    logic              chip_select_b;
    logic              output_enable_b;
    logic              write_enable_b;
    logic              hard_reset_b;
    logic              program_enable_at_level;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] data;
  } fbm_bus_in_t;

  typedef struct packed {
    fbm_state_t        state;
    fbm_setup_t        setup;
    logic              rd_status;
    logic              page_mode;
    logic [7:0]        status;
    logic              wr_act;
    logic [ADDR_W-1:0] cap_addr;
    logic [DATA_W-1:0] cap_data;
    logic [ADDR_W-1:0] wsm_addr;
    logic [DATA_W-1:0] wsm_data;
    logic [CNT_W-1:0]  cnt;
    logic [DATA_W-1:0] dout;
  } fbm_core_t;

  localparam fbm_core_t CORE_RESET_VAL = '{
    state: FBM_ST_RESET, setup: FBM_SU_NONE, rd_status: 1'b0, page_mode: 1'b1,
    status: SR_RESET_VAL, wr_act: 1'b0, cap_addr: '0, cap_data: '0,
    wsm_addr: '0, wsm_data: '0, cnt: '0, dout: '0};

endpackage

// File: src/fbm_mem.sv
// Word array with one write port and a registered read port
module fbm_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  // Write port
  input  wire logic              i_we,
  input  wire logic [ADDR_W-1:0] i_waddr,
  input  wire logic [DATA_W-1:0] i_wdata,
  // Read port
  input  wire logic [ADDR_W-1:0] i_raddr,
  output logic      [DATA_W-1:0] o_rdata
);

  logic [DATA_W-1:0] mem_q [2**ADDR_W];
  logic [DATA_W-1:0] rdata_q;

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[i_raddr];
    end
  end

  assign o_rdata = rdata_q;

endmodule

// File: src/fbm_core.sv
// Bus decode, reset handling and write sequencer of the flash front end
// Overview of operation
// RQ1: Hard reset low disables internals and floats every output.
// RQ2: Leaving reset comes up in asynchronous page read mode.
// RQ3: Hard reset during program or erase aborts it; content undefined.
// RQ4: Host holds hard reset low at least 100 ns.
// RQ5: Reset completes within 20 us during erase, 10 us during program.
// RQ6: Reset with no operation running completes within the least pulse time.
// RQ7: Host holds hard reset until 60 us after core supply is valid.
// RQ8: Host waits a recovery interval after reset release before any access.
// RQ9: Host should keep reset asserted through supply ramps.
// RQ10: Chip select active means selected; inactive means standby.
// RQ11: Data bus drives on output enable, listens on write enable.
// RQ12: Never both enables; if both, output enable wins and reads.
// RQ13: Host reads with chip select and output enable, others inactive.
// RQ14: Selected read drives addressed data onto the data bus.
// RQ15: Supply at lockout level allows reads, refuses any alteration.
// RQ16: Array writes need enable level; busy pin driven low meanwhile.
// RQ17: All control arrives as commands through the unmapped command interface.
// RQ18: Write state machine runs erase and program alone after acceptance.
// RQ19: Chip select inactive floats data regardless of output enable.
// RQ20: Writes latch address and data when the first strobe rises.
// RQ21: After power-up or reset: array read, status 0x80.
module fbm_core #(
  parameter int RECOVERY_CYC = 27,
  parameter int PROG_CYC     = 64,
  parameter int ERASE_CYC    = 128
) (
  // Clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_b,
  // Host pins in
  input  wire fbm_pkg::fbm_bus_in_t        i_bus,
  // Data bus out
  output logic      [fbm_pkg::DATA_W-1:0]  o_data,
  output logic                             o_data_oe,
  // Ready/busy open drain
  output logic                             o_ready_busy_out,
  output logic                             o_ready_busy_oe
);

  // ****************************************
  // State
  // ****************************************
  localparam int CNT_W      = fbm_pkg::CNT_W;
  localparam int PROG_LAST  = PROG_CYC - 1;
  localparam int ERASE_LAST = ERASE_CYC - 1;
  localparam int WAKE_LAST  = RECOVERY_CYC - 1;

  fbm_pkg::fbm_core_t              s_q;
  fbm_pkg::fbm_core_t              s_d;
  logic                            awake;
  logic                            wr_now;
  logic                            commit;
  logic                            mem_we;
  logic [fbm_pkg::DATA_W-1:0]      mem_wdata;
  logic [fbm_pkg::DATA_W-1:0]      mem_rdata;

  fbm_mem #(
    .ADDR_W (fbm_pkg::ADDR_W),
    .DATA_W (fbm_pkg::DATA_W)
  ) u_mem (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_we    (mem_we),
    .i_waddr (s_q.wsm_addr),
    .i_wdata (mem_wdata),
    .i_raddr (i_bus.address),
    .o_rdata (mem_rdata)
  );

  // ****************************************
  // Pin decode
  // ****************************************
  assign awake = i_bus.hard_reset_b && (s_q.state == fbm_pkg::FBM_ST_IDLE
                 || s_q.state == fbm_pkg::FBM_ST_PROG || s_q.state == fbm_pkg::FBM_ST_ERASE);
  // Output enable masks a write strobe
  assign wr_now = awake && !i_bus.chip_select_b && !i_bus.write_enable_b
                  && i_bus.output_enable_b; // RQ12 RQ11
  // Commit when the first of the two strobes rises
  assign commit = s_q.wr_act && !wr_now; // RQ20
  assign o_data = s_q.dout;
  assign o_data_oe = awake && !i_bus.chip_select_b
                     && !i_bus.output_enable_b; // RQ1 RQ10 RQ11 RQ14 RQ19
  assign o_ready_busy_out = 1'b0;
  assign o_ready_busy_oe = i_bus.hard_reset_b && (s_q.state == fbm_pkg::FBM_ST_PROG
                           || s_q.state == fbm_pkg::FBM_ST_ERASE); // RQ16 RQ1

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_wdata = s_q.wsm_data;
    s_d.wr_act = wr_now;
    if (wr_now) begin
      s_d.cap_addr = i_bus.address;
      s_d.cap_data = i_bus.data;
    end
    s_d.dout = s_q.rd_status ? {8'h00, s_q.status} : mem_rdata; // RQ14
    case (s_q.state)
      fbm_pkg::FBM_ST_RESET: begin
        s_d = fbm_pkg::CORE_RESET_VAL; // RQ2 RQ21
        if (i_bus.hard_reset_b) begin
          s_d.state = fbm_pkg::FBM_ST_WAKE;
        end
      end
      fbm_pkg::FBM_ST_WAKE: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == CNT_W'(WAKE_LAST)) begin
          s_d.state = fbm_pkg::FBM_ST_IDLE;
          s_d.cnt = '0;
        end
      end
      fbm_pkg::FBM_ST_IDLE: begin
        if (commit) begin // RQ17
          s_d.setup = fbm_pkg::FBM_SU_NONE;
          s_d.cnt = '0;
          if (s_q.setup == fbm_pkg::FBM_SU_PROG) begin
            if (!i_bus.program_enable_at_level) begin
              s_d.status[fbm_pkg::SR_PROGRAM_ENABLE_SUPPLY_ERR] = 1'b1; // RQ15
              s_d.status[fbm_pkg::SR_PROG_ERR] = 1'b1;
            end else begin
              s_d.state = fbm_pkg::FBM_ST_PROG; // RQ18 RQ16
              s_d.wsm_addr = s_q.cap_addr;
              s_d.wsm_data = s_q.cap_data;
              s_d.status[fbm_pkg::SR_READY] = 1'b0;
            end
          end else if (s_q.setup == fbm_pkg::FBM_SU_ERASE) begin
            if (s_q.cap_data[7:0] != fbm_pkg::CMD_CONFIRM) begin
              s_d.status[fbm_pkg::SR_ERASE_ERR] = 1'b1;
              s_d.status[fbm_pkg::SR_PROG_ERR] = 1'b1;
            end else if (!i_bus.program_enable_at_level) begin
              s_d.status[fbm_pkg::SR_PROGRAM_ENABLE_SUPPLY_ERR] = 1'b1; // RQ15
              s_d.status[fbm_pkg::SR_ERASE_ERR] = 1'b1;
            end else begin
              s_d.state = fbm_pkg::FBM_ST_ERASE; // RQ18 RQ16
              s_d.wsm_addr = {s_q.cap_addr[fbm_pkg::ADDR_W-1:fbm_pkg::BLK_W],
                              {fbm_pkg::BLK_W{1'b0}}};
              s_d.status[fbm_pkg::SR_READY] = 1'b0;
            end
          end else if (s_q.cap_data[7:0] == fbm_pkg::CMD_READ_ARRAY) begin
            s_d.rd_status = 1'b0;
          end else if (s_q.cap_data[7:0] == fbm_pkg::CMD_READ_STATUS) begin
            s_d.rd_status = 1'b1;
          end else if (s_q.cap_data[7:0] == fbm_pkg::CMD_CLEAR_STATUS) begin
            s_d.status = s_q.status & fbm_pkg::SR_CLEAR_MSK;
          end else if (s_q.cap_data[7:0] == fbm_pkg::CMD_PROGRAM
                       || s_q.cap_data[7:0] == fbm_pkg::CMD_PROGRAM_ALT) begin
            s_d.setup = fbm_pkg::FBM_SU_PROG;
            s_d.rd_status = 1'b1;
          end else if (s_q.cap_data[7:0] == fbm_pkg::CMD_ERASE) begin
            s_d.setup = fbm_pkg::FBM_SU_ERASE;
            s_d.rd_status = 1'b1;
          end
        end
      end
      fbm_pkg::FBM_ST_PROG: begin
        if (s_q.cnt == CNT_W'(PROG_LAST)) begin
          mem_we = 1'b1; // RQ18
          s_d.state = fbm_pkg::FBM_ST_IDLE;
          s_d.status[fbm_pkg::SR_READY] = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end
      fbm_pkg::FBM_ST_ERASE: begin
        if (s_q.cnt != CNT_W'(ERASE_LAST)) begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end else begin
          mem_we = 1'b1; // RQ18
          mem_wdata = fbm_pkg::ERASED_WORD;
          s_d.wsm_addr = s_q.wsm_addr + 8'h01;
          if (&s_q.wsm_addr[fbm_pkg::BLK_W-1:0]) begin
            s_d.state = fbm_pkg::FBM_ST_IDLE;
            s_d.status[fbm_pkg::SR_READY] = 1'b1;
          end
        end
      end
      default: begin
        s_d.state = fbm_pkg::FBM_ST_RESET;
      end
    endcase
    // Any cycle of hard reset aborts and parks the device
    if (!i_bus.hard_reset_b) begin
      s_d.state = fbm_pkg::FBM_ST_RESET; // RQ3 RQ5 RQ6 RQ1
      s_d.wr_act = 1'b0;
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s_q <= fbm_pkg::CORE_RESET_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  property p_reset_floats;
    !i_bus.hard_reset_b |-> !o_data_oe && !o_ready_busy_oe ##1 s_q.state == fbm_pkg::FBM_ST_RESET;
  endproperty
  a_reset_floats: assert property (p_reset_floats) else $error("outputs live in reset"); // RQ1

  property p_exit_mode;
    (s_q.state == fbm_pkg::FBM_ST_WAKE && s_d.state == fbm_pkg::FBM_ST_IDLE) |=>
      s_q.page_mode && !s_q.rd_status && s_q.status == 8'h80;
  endproperty
  a_exit_mode: assert property (p_exit_mode) else $error("wrong mode after reset"); // RQ2 RQ21

  property p_abort;
    (s_q.state == fbm_pkg::FBM_ST_PROG || s_q.state == fbm_pkg::FBM_ST_ERASE)
      && !i_bus.hard_reset_b |-> !mem_we ##1 s_q.state == fbm_pkg::FBM_ST_RESET;
  endproperty
  a_abort: assert property (p_abort) else $error("operation not aborted"); // RQ3 RQ5

  property p_idle_reset;
    s_q.state == fbm_pkg::FBM_ST_IDLE && !i_bus.hard_reset_b |=>
      s_q.state == fbm_pkg::FBM_ST_RESET;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("idle reset slow"); // RQ6

  property p_standby_float;
    i_bus.chip_select_b |-> !o_data_oe;
  endproperty
  a_standby_float: assert property (p_standby_float) else $error("oe in standby"); // RQ10 RQ19

  property p_read_drive;
    s_q.state == fbm_pkg::FBM_ST_IDLE && i_bus.hard_reset_b && !i_bus.chip_select_b
      && !i_bus.output_enable_b |-> o_data_oe ##2 (o_data == {8'h00, $past(s_q.status, 1)}
      || !$past(s_q.rd_status, 1));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven"); // RQ11 RQ14

  property p_oe_wins;
    !i_bus.output_enable_b && !i_bus.write_enable_b |=> !s_q.wr_act;
  endproperty
  a_oe_wins: assert property (p_oe_wins) else $error("write taken with oe"); // RQ12

  property p_lockout;
    s_q.state == fbm_pkg::FBM_ST_IDLE && commit && s_q.setup != fbm_pkg::FBM_SU_NONE
      && !i_bus.program_enable_at_level && i_bus.hard_reset_b
      && (s_q.setup == fbm_pkg::FBM_SU_PROG || s_q.cap_data[7:0] == fbm_pkg::CMD_CONFIRM)
      |-> !mem_we ##1
      s_q.state == fbm_pkg::FBM_ST_IDLE && s_q.status[fbm_pkg::SR_PROGRAM_ENABLE_SUPPLY_ERR];
  endproperty
  a_lockout: assert property (p_lockout) else $error("alteration under lockout"); // RQ15

  property p_busy_pin;
    s_q.state == fbm_pkg::FBM_ST_PROG && i_bus.hard_reset_b |->
      o_ready_busy_oe && !o_ready_busy_out && !s_q.status[fbm_pkg::SR_READY];
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy not shown"); // RQ16 RQ18

  property p_status_cmd;
    s_q.state == fbm_pkg::FBM_ST_IDLE && commit && s_q.setup == fbm_pkg::FBM_SU_NONE
      && i_bus.hard_reset_b && s_q.cap_data[7:0] == fbm_pkg::CMD_READ_STATUS |=> s_q.rd_status;
  endproperty
  a_status_cmd: assert property (p_status_cmd) else $error("command not taken"); // RQ17 RQ20

  c_prog_done:  cover property (s_q.state == fbm_pkg::FBM_ST_PROG
                                ##1 s_q.state == fbm_pkg::FBM_ST_IDLE);
  c_erase_done: cover property (s_q.state == fbm_pkg::FBM_ST_ERASE
                                ##1 s_q.state == fbm_pkg::FBM_ST_IDLE);
  c_abort:      cover property (s_q.state == fbm_pkg::FBM_ST_ERASE && !i_bus.hard_reset_b);
  c_read:       cover property (o_data_oe && s_q.rd_status);

endmodule

// File: sim/fbm_host.sv
// Host-side bus model that drives the flash pins
module fbm_host #(
  parameter int SUPPLY_CYC  = 7500,
  parameter int PULSE_CYC   = fbm_pkg::RESET_LOW_PULSE_CYC,
  parameter int RECOVER_CYC = 8
) (
  // Clock
  input  wire logic            i_mclk,
  // Pins out
  output fbm_pkg::fbm_bus_in_t o_bus
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Pin driving
  // ****************************************
  initial begin
    o_bus = '{chip_select_b: 1'b1, output_enable_b: 1'b1, write_enable_b: 1'b1,
              hard_reset_b: 1'b0, program_enable_at_level: 1'b1, address: '0,
              data: 16'hA5A5};
  end

  task automatic release_reset(input int hold);
    repeat (hold) @(posedge i_mclk);
    o_bus.hard_reset_b <= 1'b1;
    repeat (RECOVER_CYC) @(posedge i_mclk);
  endtask

  task automatic power_up();
    release_reset(SUPPLY_CYC);
  endtask

  task automatic set_reset(input logic lvl);
    @(posedge i_mclk);
    o_bus.hard_reset_b <= lvl;
  endtask

  task automatic set_supply(input logic lvl);
    o_bus.program_enable_at_level <= lvl;
  endtask

  // Output enable low only where a scenario asks for the clash
  task automatic write(input logic [7:0] a, input logic [15:0] d, input logic oe_b);
    @(posedge i_mclk);
    o_bus.chip_select_b   <= 1'b0;
    o_bus.write_enable_b  <= 1'b0;
    o_bus.output_enable_b <= oe_b;
    o_bus.address         <= a;
    o_bus.data            <= d;
    @(posedge i_mclk);
    o_bus.chip_select_b   <= 1'b1;
    o_bus.write_enable_b  <= 1'b1;
    o_bus.output_enable_b <= 1'b1;
    o_bus.data            <= ~d;
    repeat (2) @(posedge i_mclk);
  endtask

  // Write strobe rises first while chip select stays low a cycle longer
  task automatic write_we_first(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_bus.chip_select_b   <= 1'b0;
    o_bus.write_enable_b  <= 1'b0;
    o_bus.output_enable_b <= 1'b1;
    o_bus.address         <= a;
    o_bus.data            <= d;
    @(posedge i_mclk);
    o_bus.write_enable_b  <= 1'b1;
    o_bus.address         <= ~a;
    o_bus.data            <= ~d;
    @(posedge i_mclk);
    o_bus.chip_select_b   <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask

  task automatic read_on(input logic [7:0] a, input logic cs_b, input logic oe_b);
    @(posedge i_mclk);
    o_bus.chip_select_b   <= cs_b;
    o_bus.output_enable_b <= oe_b;
    o_bus.write_enable_b  <= 1'b1;
    o_bus.address         <= a;
    o_bus.data            <= ~o_bus.data;
  endtask

  task automatic read_off();
    @(posedge i_mclk);
    o_bus.chip_select_b   <= 1'b1;
    o_bus.output_enable_b <= 1'b1;
  endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench of the flash bus front end
`define CHK(what, exp, act) begin total_checks++; if ((act) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, act); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REC = 4;

  // ****************************************
  // Signals and instances
  // ****************************************
  logic                 i_mclk = 1'b0;
  logic                 i_rst_b = 1'b0;
  fbm_pkg::fbm_bus_in_t host_bus;
  fbm_pkg::fbm_bus_in_t bus_in;
  logic [15:0]          dout;
  logic                 data_oe;
  logic                 rb_out;
  logic                 rb_oe;
  logic [15:0]          v;
  logic                 e;
  int                   miscompares = 0;
  int                   total_checks = 0;
  int                   cycles = 0;

  always #4 i_mclk = ~i_mclk;
  // Shared data wire
  always_comb begin
    bus_in = host_bus;
    if (data_oe) bus_in.data = dout;
  end

  fbm_host #(.RECOVER_CYC(REC + 4)) host (.i_mclk(i_mclk), .o_bus(host_bus));
  fbm_core #(.RECOVERY_CYC(REC), .PROG_CYC(4), .ERASE_CYC(4)) uut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_bus(bus_in), .o_data(dout),
    .o_data_oe(data_oe), .o_ready_busy_out(rb_out), .o_ready_busy_oe(rb_oe));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic rd(input logic [7:0] a, input logic cs_b, input logic oe_b);
    host.read_on(a, cs_b, oe_b);
    repeat (3) @(posedge i_mclk);
    #1;
    v = dout;
    e = data_oe;
    host.read_off();
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    #1;
    while (rb_oe === 1'b1 && n < 200) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    `CHK("busy ends", 1'b1, n < 200)
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_up();
    host.read_on(8'h05, 1'b0, 1'b0);
    repeat (20) @(posedge i_mclk);
    #1;
    `CHK("oe in reset", 1'b0, data_oe)
    host.read_off();
    host.power_up();
    host.write(8'h00, 16'h0070, 1'b1);
    rd(8'h00, 1'b0, 1'b0);
    `CHK("oe read", 1'b1, e)
    `CHK("status after power-up", 8'h80, v[7:0])
  endtask

  task automatic t_standby();
    rd(8'h05, 1'b1, 1'b0);
    `CHK("oe deselected", 1'b0, e)
    rd(8'h05, 1'b0, 1'b1);
    `CHK("oe disabled", 1'b0, e)
  endtask

  task automatic t_program();
    host.write(8'h05, 16'h0040, 1'b1);
    host.write(8'h05, 16'h1234, 1'b1);
    #1;
    `CHK("busy driven", 1'b1, rb_oe)
    `CHK("busy level", 1'b0, rb_out)
    wait_ready();
    host.write(8'h00, 16'h00FF, 1'b1);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("programmed word", 16'h1234, v)
    host.write(8'h00, 16'h0070, 1'b1);
    host.write(8'h00, 16'h00FF, 1'b1);
  endtask

  task automatic t_both_enables();
    host.write(8'h00, 16'h0070, 1'b0);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("clash stays array", 16'h1234, v)
    host.write_we_first(8'h00, 16'h0070);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("we first latches", 8'h80, v[7:0])
  endtask

  task automatic t_lockout();
    host.set_supply(1'b0);
    host.write(8'h05, 16'h0040, 1'b1);
    host.write(8'h05, 16'h0000, 1'b1);
    #1;
    `CHK("no busy locked", 1'b0, rb_oe)
    rd(8'h05, 1'b0, 1'b0);
    `CHK("lockout status", 8'h98, v[7:0])
    host.write(8'h00, 16'h0050, 1'b1);
    host.write(8'h00, 16'h0070, 1'b1);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("cleared status", 8'h80, v[7:0])
    host.write(8'h00, 16'h00FF, 1'b1);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("word kept", 16'h1234, v)
    host.set_supply(1'b1);
  endtask

  task automatic t_erase();
    host.write(8'h03, 16'h0020, 1'b1);
    host.write(8'h03, 16'h00D0, 1'b1);
    wait_ready();
    host.write(8'h00, 16'h00FF, 1'b1);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("erased word", fbm_pkg::ERASED_WORD, v)
    host.write(8'h03, 16'h0020, 1'b1);
    host.write(8'h03, 16'h0055, 1'b1);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("bad confirm status", 8'hB0, v[7:0])
    host.write(8'h00, 16'h0050, 1'b1);
  endtask

  task automatic t_reset_abort();
    host.write(8'h20, 16'h0010, 1'b1);
    host.write(8'h20, 16'h5A5A, 1'b1);
    #1;
    `CHK("alt program busy", 1'b1, rb_oe)
    host.set_reset(1'b0);
    #1;
    `CHK("busy on abort", 1'b0, rb_oe)
    host.read_on(8'h05, 1'b0, 1'b0);
    #1;
    `CHK("oe in hard reset", 1'b0, data_oe)
    host.read_off();
    host.release_reset(fbm_pkg::RESET_LOW_PULSE_CYC);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("array after reset", fbm_pkg::ERASED_WORD, v)
    host.write(8'h00, 16'h0070, 1'b1);
    rd(8'h05, 1'b0, 1'b0);
    `CHK("status after reset", 8'h80, v[7:0])
  endtask

  // ****************************************
  // Sequence and timeout
  // ****************************************
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_power_up();
    t_standby();
    t_program();
    t_both_enables();
    t_lockout();
    t_erase();
    t_reset_abort();
    summarize();
  end
endmodule
